// ==== logic/headset_detect_aux_pin_ctrl.v ====
// Headset and button detection with debounce, plus multipurpose pin muxing.
// Assumes analog comparators, clocks and word selects arrive from elsewhere.
`timescale 1ns/1ns
`default_nettype none
`include "headset_aux_defines.vh"

module headset_detect_aux_pin_ctrl (
  // Clock and reset
  input wire core_clk_i,
  input wire reset_i,
  // Register port
  input wire [5:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [15:0] reg_wdata_i,
  output reg [15:0] reg_rdata_o,
  // Analog detection comparators (asynchronous)
  input wire [1:0] headset_kind_raw_i,
  input wire button_raw_i,
  // Clock sources, same domain
  input wire pll_en_i,
  input wire clock_output_mode_i,
  input wire adc_word_select_i,
  // Multipurpose pins
  input wire multipurpose_pin_one_i,
  output reg multipurpose_pin_one_o,
  output reg multipurpose_pin_one_oe_o,
  input wire multipurpose_pin_two_i,
  output reg multipurpose_pin_two_o,
  output reg multipurpose_pin_two_oe_o
);

  // ===================================================================
  // Control registers
  reg [15:0] det_cfg;
  reg [15:0] pin_ctrl;
  wire det_en = det_cfg[`DET_EN_BIT];
  wire [1:0] hdeb_sel = det_cfg[`DET_HDEB_HI:`DET_HDEB_LO];
  wire [1:0] bdeb_sel = det_cfg[`DET_BDEB_HI:`DET_BDEB_LO];
  wire [1:0] fsel = det_cfg[`DET_FSEL_HI:`DET_FSEL_LO];

  always @(posedge core_clk_i) begin
    if (reset_i) begin
      det_cfg <= `DET_RESET;
      pin_ctrl <= `PIN_RESET;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `ADDR_DETECT_CFG) begin
        det_cfg <= reg_wdata_i & `DET_WRITE_MASK;
      end else if (reg_addr_i == `ADDR_PIN_CTRL) begin
        pin_ctrl <= reg_wdata_i & `PIN_WRITE_MASK;
      end
    end
  end

  // ===================================================================
  // Input synchronisers, two flops each
  reg [4:0] sync_a;
  reg [4:0] sync_b;
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
    end else begin
      sync_a <= {multipurpose_pin_two_i, multipurpose_pin_one_i, button_raw_i,
                 headset_kind_raw_i};
      sync_b <= sync_a;
    end
  end
  wire [1:0] kind_s = sync_b[1:0];
  wire button_s = sync_b[2];

  // ===================================================================
  // Millisecond tick and power-of-two tick dividers
  localparam integer MS_COUNT = `MS_CYCLES;
  reg [16:0] ms_cnt;
  reg [3:0] ms_div;
  reg ms_tick;
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      ms_cnt <= 17'h0_0000;
      ms_div <= 4'h0;
      ms_tick <= 1'b0;
    end else if (ms_cnt == MS_COUNT[16:0] - 17'h0_0001) begin
      ms_cnt <= 17'h0_0000;
      ms_div <= ms_div + 4'h1;
      ms_tick <= 1'b1;
    end else begin
      ms_cnt <= ms_cnt + 17'h0_0001;
      ms_tick <= 1'b0;
    end
  end
  // Tick of 2^n ms fires when low n bits of divider wrapped to zero
  function tick_of;
    input [2:0] n;
    input [3:0] div;
    begin
      tick_of = ms_tick && ((div & ((4'h1 << n) - 4'h1)) == 4'h0);
    end
  endfunction

  wire h_tick = tick_of({1'b0, hdeb_sel} + 3'h1, ms_div);
  wire b_tick = tick_of({1'b0, bdeb_sel} - 3'h1, ms_div);

  // ===================================================================
  // Debouncers: eight ticks of stable input commit the new state; button select BDEB_NONE commits at once
  reg [1:0] kind_q;
  reg [3:0] h_cnt;
  reg button_q;
  reg [3:0] b_cnt;
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      kind_q <= `KIND_NONE;
      h_cnt <= 4'h0;
      button_q <= 1'b0;
      b_cnt <= 4'h0;
    end else if (!det_en) begin
      kind_q <= `KIND_NONE;
      h_cnt <= 4'h0;
      button_q <= 1'b0;
      b_cnt <= 4'h0;
    end else begin
      if (kind_s == kind_q) begin
        h_cnt <= 4'h0;
      end else if (h_tick) begin
        if (h_cnt == `DEB_TICKS - 4'h1) begin
          kind_q <= kind_s;
          h_cnt <= 4'h0;
        end else begin
          h_cnt <= h_cnt + 4'h1;
        end
      end
      if (bdeb_sel == `BDEB_NONE) begin
        button_q <= button_s;
        b_cnt <= 4'h0;
      end else if (button_s == button_q) begin
        b_cnt <= 4'h0;
      end else if (b_tick) begin
        if (b_cnt == `DEB_TICKS - 4'h1) begin
          button_q <= button_s;
          b_cnt <= 4'h0;
        end else begin
          b_cnt <= b_cnt + 4'h1;
        end
      end
    end
  end
  wire present = (kind_q != `KIND_NONE);
  wire detect_irq = present;

  // ===================================================================
  // Pin muxing
  wire gp_two = pin_ctrl[`PIN_O2EN_BIT] | pin_ctrl[`PIN_I2EN_BIT];
  wire gp_one = pin_ctrl[`PIN_O1EN_BIT] | pin_ctrl[`PIN_I1EN_BIT];
  reg next_two_o;
  reg next_two_oe;
  reg next_one_o;
  reg next_one_oe;
  always @* begin
    next_two_o = 1'b0;
    next_two_oe = 1'b0;
    next_one_o = 1'b0;
    next_one_oe = 1'b0;
    if (pin_ctrl[`PIN_O2EN_BIT]) begin
      next_two_o = pin_ctrl[`PIN_O2LV_BIT];
      next_two_oe = 1'b1;
    end else if (!gp_two && det_cfg[`DET_IRQ2_BIT]) begin
      next_two_o = detect_irq;
      next_two_oe = 1'b1;
    end else if (!gp_two && det_cfg[`DET_CLK2_BIT] && pll_en_i) begin
      next_two_o = clock_output_mode_i;
      next_two_oe = 1'b1;
    end
    if (pin_ctrl[`PIN_O1EN_BIT]) begin
      next_one_o = pin_ctrl[`PIN_O1LV_BIT];
      next_one_oe = 1'b1;
    end else if (!gp_one && det_cfg[`DET_IRQ1_BIT]) begin
      next_one_o = detect_irq;
      next_one_oe = 1'b1;
    end else if (!gp_one && fsel == `FSEL_BUTTON_IRQ) begin
      next_one_o = button_q;
      next_one_oe = 1'b1;
    end else if (!gp_one && fsel == `FSEL_ADC_WS) begin
      next_one_o = adc_word_select_i;
      next_one_oe = 1'b1;
    end
  end

  // ===================================================================
  // Input level flags and outputs
  reg pin_one_in_level;
  reg pin_two_in_level;
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      pin_one_in_level <= 1'b0;
      pin_two_in_level <= 1'b0;
      multipurpose_pin_one_o <= 1'b0;
      multipurpose_pin_one_oe_o <= 1'b0;
      multipurpose_pin_two_o <= 1'b0;
      multipurpose_pin_two_oe_o <= 1'b0;
    end else begin
      pin_one_in_level <= pin_ctrl[`PIN_I1EN_BIT] & sync_b[3];
      pin_two_in_level <= pin_ctrl[`PIN_I2EN_BIT] & sync_b[4];
      multipurpose_pin_one_o <= next_one_o;
      multipurpose_pin_one_oe_o <= next_one_oe;
      multipurpose_pin_two_o <= next_two_o;
      multipurpose_pin_two_oe_o <= next_two_oe;
    end
  end

  // ===================================================================
  // Read data, registered; unmapped reads zero
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_addr_i == `ADDR_DETECT_CFG) begin
      reg_rdata_o <= {det_cfg[`DET_EN_BIT], kind_q, present, button_q,
                      det_cfg[`DET_HDEB_HI:0]};
    end else if (reg_addr_i == `ADDR_PIN_CTRL) begin
      reg_rdata_o <= {pin_ctrl[15:13], pin_two_in_level, pin_ctrl[11:9],
                      pin_one_in_level, 8'h00};
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

endmodule
`default_nettype wire

// ==== logic/headset_aux_defines.vh ====
// Constants for the headset detect and multipurpose pin control block.
// Assumes a 100 MHz core clock and a simple word-wide register port.
`ifndef HEADSET_AUX_DEFINES_VH
`define HEADSET_AUX_DEFINES_VH

// =====================================================================
// Register addresses
`define ADDR_DETECT_CFG 6'h22
`define ADDR_PIN_CTRL 6'h23

// =====================================================================
// Detection register fields
`define DET_EN_BIT 15
`define DET_KIND_HI 14
`define DET_KIND_LO 13
`define DET_PRESENT_BIT 12
`define DET_BUTTON_BIT 11
`define DET_HDEB_HI 10
`define DET_HDEB_LO 9
`define DET_BDEB_HI 7
`define DET_BDEB_LO 6
`define DET_IRQ2_BIT 4
`define DET_IRQ1_BIT 3
`define DET_CLK2_BIT 2
`define DET_FSEL_HI 1
`define DET_FSEL_LO 0
`define DET_WRITE_MASK 16'h86DF
`define DET_RESET 16'h0200

// =====================================================================
// Pin control register fields
`define PIN_O2EN_BIT 15
`define PIN_O2LV_BIT 14
`define PIN_I2EN_BIT 13
`define PIN_I2LV_BIT 12
`define PIN_O1EN_BIT 11
`define PIN_O1LV_BIT 10
`define PIN_I1EN_BIT 9
`define PIN_I1LV_BIT 8
`define PIN_WRITE_MASK 16'hEE00
`define PIN_RESET 16'h0000

// =====================================================================
// Pin one function select codes
`define FSEL_BUTTON_IRQ 2'h2
`define FSEL_ADC_WS 2'h3

// =====================================================================
// Kind codes and debounce
`define KIND_NONE 2'h0
`define HDEB_RESET 2'h1
`define BDEB_NONE 2'h0
`define TICK_MS 1
`define CLK_MHZ 100
`define MS_CYCLES (`TICK_MS * `CLK_MHZ * 1000)
`define DEB_TICKS 4'h8

`endif

// ==== sim/headset_aux_assertions.sv ====
// Checker for the headset detect and multipurpose pin block.
// Sees the block's ports only; pin outputs lag their cause by one edge.
`timescale 1ns/1ns
`default_nettype none
// ==== Checker
module headset_aux_assertions (
  // Clock, reset and register port
  input wire core_clk_i, reset_i, reg_wr_i,
  input wire [5:0] reg_addr_i,
  input wire [15:0] reg_wdata_i, reg_rdata_o,
  // Sources and pins
  input wire pll_en_i, clock_output_mode_i, adc_word_select_i,
  input wire multipurpose_pin_one_o, multipurpose_pin_one_oe_o,
  input wire multipurpose_pin_two_o, multipurpose_pin_two_oe_o
);
  logic [15:0] det, pin;
  wire e1 = multipurpose_pin_one_oe_o;
  wire q1 = multipurpose_pin_one_o;
  wire e2 = multipurpose_pin_two_oe_o;
  wire q2 = multipurpose_pin_two_o;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  // Shadow of the writable bits
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      det <= 16'h0200;
      pin <= 16'h0000;
    end else if (reg_wr_i && reg_addr_i == 6'h22) begin
      det <= reg_wdata_i & 16'h86DF;
    end else if (reg_wr_i && reg_addr_i == 6'h23) begin
      pin <= reg_wdata_i & 16'hEE00;
    end
  end
  a_gpo_pin_two: assert property (pin[15] |=> e2 && q2 == $past(pin[14]))
    else $error("pin two output level wrong");
  a_gpo_pin_one: assert property (pin[11] |=> e1 && q1 == $past(pin[10]))
    else $error("pin one output level wrong");
  a_pin_two_off: assert property (!pin[15] && (pin[13] || !det[4] && !det[2]) |=> !e2)
    else $error("pin two driven while unselected");
  a_pin_one_off: assert property (!pin[11] && (pin[9] || !det[3] && !det[1]) |=> !e1)
    else $error("pin one driven while unselected");
  a_irq_pin_two: assert property (det[4] && !pin[15] && !pin[13] |=> e2)
    else $error("pin two detect interrupt not driven");
  a_irq_pin_one: assert property (det[3] && !pin[11] && !pin[9] |=> e1)
    else $error("pin one detect interrupt not driven");
  a_clock_pin_two: assert property (det[2] && pll_en_i && {pin[15], pin[13], det[4]} == 3'h0
    |=> e2 && q2 == $past(clock_output_mode_i)) else $error("pin two clock missing");
  a_ws_pin_one: assert property (det[1:0] == 2'h3 && {pin[11], pin[9], det[3]} == 3'h0
    |=> e1 && q1 == $past(adc_word_select_i)) else $error("pin one word select missing");
  a_det_rsvd_zero: assert property ($past(reg_addr_i) == 6'h22
    |-> reg_rdata_o[8] == 1'b0 && reg_rdata_o[5] == 1'b0) else $error("detect reserved set");
  a_pin_rsvd_zero: assert property ($past(reg_addr_i) == 6'h23
    |-> reg_rdata_o[7:0] == 8'h00) else $error("pin reserved byte set");
endmodule
bind headset_detect_aux_pin_ctrl headset_aux_assertions chk (.*);
`default_nettype wire

// ==== sim/pin_host_model.sv ====
// Host processor side of the two multipurpose pins.
// Host drives its level only while the block leaves a pin released.
`timescale 1ns/1ns
`default_nettype none
// ==== Pin host
module pin_host_model (
  // Block drive
  input wire logic o1_i, e1_i, o2_i, e2_i,
  // Host levels and resolved pin wires
  input wire logic h1_i, h2_i,
  output logic p1_o, p2_o
);
  assign p1_o = e1_i ? o1_i : h1_i;
  assign p2_o = e2_i ? o2_i : h2_i;
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the headset detect and multipurpose pin block.
// Assumes the pin host model resolves both pin wires.
`timescale 1ns/1ns
`default_nettype none
// ==== Bench
module tb_top;
  logic core_clk_i = 0, reset_i = 1, reg_wr_i = 0, button_raw_i = 0, pll_en_i = 0;
  logic clock_output_mode_i = 0, adc_word_select_i = 0, h1 = 0, h2 = 0;
  logic [5:0] reg_addr_i = 6'h00;
  logic [15:0] reg_wdata_i = 16'h0000, det = 16'h0000, pin = 16'h0000;
  logic [1:0] headset_kind_raw_i = 2'h0;
  wire [15:0] reg_rdata_o;
  wire multipurpose_pin_one_i, multipurpose_pin_one_o, multipurpose_pin_one_oe_o;
  wire multipurpose_pin_two_i, multipurpose_pin_two_o, multipurpose_pin_two_oe_o;
  wire [15:0] pins = {12'h000, multipurpose_pin_one_oe_o, multipurpose_pin_one_oe_o &
    multipurpose_pin_one_o, multipurpose_pin_two_oe_o, multipurpose_pin_two_oe_o &
    multipurpose_pin_two_o};
  int n_mismatch = 0, compares = 0, i;
  headset_detect_aux_pin_ctrl uut (.*);
  pin_host_model host (.o1_i(multipurpose_pin_one_o), .e1_i(multipurpose_pin_one_oe_o),
    .o2_i(multipurpose_pin_two_o), .e2_i(multipurpose_pin_two_oe_o), .h1_i(h1), .h2_i(h2),
    .p1_o(multipurpose_pin_one_i), .p2_o(multipurpose_pin_two_i));
  initial forever #5 core_clk_i = ~core_clk_i;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic wreg(input logic [5:0] a, input logic [15:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1;
    step(1);
    reg_wr_i = 0;
    step(1);
  endtask
  task automatic rchk(input logic [5:0] a, input logic [15:0] exp);
    reg_addr_i = a;
    step(1);
    check(reg_rdata_o, exp);
  endtask
  // Expected {enable, level} of one pin; present flag is low here
  function automatic logic [1:0] exp_pin(input logic two, input logic b);
    logic [2:0] g;
    g = two ? pin[15:13] : pin[11:9];
    if (g[2]) return {1'b1, g[1]};
    if (g[0]) return 2'b00;
    if (two ? det[4] : det[3]) return 2'b10;
    if (two) return {2{det[2] & pll_en_i}} & {1'b1, clock_output_mode_i};
    return {2{det[1]}} & {1'b1, det[0] ? adc_word_select_i : b};
  endfunction
  task automatic report_and_stop;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(94281));
    step(16);
    reset_i = 0;
    rchk(6'h22, 16'h0200);
    rchk(6'h23, 16'h0000);
    rchk(6'h21, 16'h0000);
    $display("test reset values done");
    for (i = 0; i < 60; i++) begin
      det = 16'($urandom) & 16'h86DF;
      pin = 16'($urandom) & 16'hEE00;
      {pll_en_i, clock_output_mode_i, adc_word_select_i, h1, h2} = 5'($urandom);
      // split rates taken for word select
      wreg(6'h22, det);
      wreg(6'h23, pin);
      step(4);
      check(pins, {12'h000, exp_pin(1'b0, 1'b0), exp_pin(1'b1, 1'b0)});
      rchk(6'h22, det);
      rchk(6'h23, pin | {3'h0, pin[13] & (pin[15] ? pin[14] : h2), 3'h0,
        pin[9] & (pin[11] ? pin[10] : h1), 8'h00});
    end
    $display("test random config done");
    det = 16'h8002;
    pin = 16'h0000;
    wreg(6'h23, pin);
    wreg(6'h22, det);
    button_raw_i = 1;
    step(10);
    rchk(6'h22, 16'h8802);
    check(pins, {12'h000, exp_pin(1'b0, 1'b1), exp_pin(1'b1, 1'b1)});
    // Short headset glitch must not show
    headset_kind_raw_i = 2'h1;
    step(1000);
    rchk(6'h22, 16'h8802);
    det = 16'h0002;
    wreg(6'h22, det);
    step(4);
    rchk(6'h22, det);
    button_raw_i = 0;
    headset_kind_raw_i = 2'h0;
    det = 16'h0000;
    wreg(6'h22, det);
    step(2);
    check(pins, 16'h0000);
    $display("test button and debounce done");
    report_and_stop();
  end
endmodule
`default_nettype wire
